// *** logic/txdh_top.sv ***
// Transmit descriptor handler: fetches, transmits and retires descriptors.
// Assumes one clock shared with memory port, MAC byte sink and register port.
//
// Chosen here: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module txdh_top import txdh_pkg::*; (
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic [REG_AW-1:0] reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [31:0]       reg_rdata,
  output logic                   irq,
  output logic                   mem_req,
  output logic                   mem_we,
  output logic      [31:0]       mem_addr,
  output logic      [31:0]       mem_wdata,
  input  wire logic              mem_ack,
  input  wire logic [31:0]       mem_rdata,
  output logic      [7:0]        tx_data,
  output logic                   tx_valid,
  input  wire logic              tx_ready,
  output logic                   tx_first,
  output logic                   tx_last,
  output logic                   tx_no_fcs,
  output logic                   tx_no_pad,
  input  wire logic              mac_done,
  input  wire logic [31:0]       mac_status
);
  ////////////////////////////////////////////////////////////////////////////
  txdh_state_t   state_r, state_nxt;
  logic [1:0]    idx_r, idx_nxt;
  logic [31:0]   stat_r, stat_nxt, ctl_r, ctl_nxt, ptr1_r, ptr1_nxt, ptr2_r, ptr2_nxt;
  logic [31:0]   cur_r, cur_nxt, base_r, base_nxt, wb_r, wb_nxt;
  logic          en_r, en_nxt, poll_r, poll_nxt, first_r, first_nxt;
  logic [IRQ_W-1:0] ist_r, ist_nxt, imask_r, imask_nxt, ev;
  logic [31:0]   rdata_r, rdata_nxt;
  logic          rd_start, rd_done, rd_req, rd_last, rd_valid;
  logic [31:0]   rd_addr, rd_maddr;
  logic [LEN_W-1:0] rd_len, len1, len2;
  logic          chain_eff, use_buf2, in_buf, final_seg;

  assign len1      = ctl_r[LEN1_LSB +: LEN_W];
  assign len2      = ctl_r[LEN2_LSB +: LEN_W];
  assign chain_eff = ctl_r[CHAIN_BIT] && !ctl_r[WRAP_BIT];
  assign use_buf2  = !chain_eff && (len2 != '0);
  assign final_seg = ctl_r[FINAL_BIT];
  assign in_buf    = (state_r == S_BUF1) || (state_r == S_BUF2);

  ////////////////////////////////////////////////////////////////////////////
  // Descriptor walker
  always_comb begin
    state_nxt = state_r;
    idx_nxt   = idx_r;
    stat_nxt  = stat_r;
    ctl_nxt   = ctl_r;
    ptr1_nxt  = ptr1_r;
    ptr2_nxt  = ptr2_r;
    cur_nxt   = cur_r;
    wb_nxt    = wb_r;
    first_nxt = first_r;
    ev        = '0;
    rd_start  = 1'b0;
    rd_addr   = ptr1_r;
    rd_len    = len1;
    case (state_r)
      S_IDLE: begin
        if (en_r && poll_r) begin
          idx_nxt   = 2'b00;
          state_nxt = S_FETCH;
        end
      end
      S_FETCH: begin
        if (mem_ack) begin
          case (idx_r)
            2'b00:   stat_nxt = mem_rdata;
            2'b01:   ctl_nxt  = mem_rdata;
            2'b10:   ptr1_nxt = mem_rdata;
            default: ptr2_nxt = mem_rdata;
          endcase
          idx_nxt = idx_r + 2'b01;
          if (idx_r == 2'(DESC_WORDS - 1)) begin
            state_nxt = S_CHECK;
          end
        end
      end
      S_CHECK: begin
        if (!stat_r[OWN_BIT]) begin
          ev[IRQ_EMPTY] = 1'b1;
          state_nxt     = S_IDLE;
        end else begin
          if (ctl_r[FIRST_BIT]) begin
            first_nxt = 1'b1;
          end
          rd_start  = (len1 != '0);
          state_nxt = S_BUF1;
        end
      end
      S_BUF1: begin
        if (rd_done || len1 == '0) begin
          if (use_buf2) begin
            rd_start  = 1'b1;
            rd_addr   = ptr2_r;
            rd_len    = len2;
            state_nxt = S_BUF2;
          end else begin
            state_nxt = final_seg ? S_WAIT : S_WBACK;
            wb_nxt    = '0;
          end
        end
      end
      S_BUF2: begin
        if (rd_done) begin
          state_nxt = final_seg ? S_WAIT : S_WBACK;
          wb_nxt    = '0;
        end
      end
      S_WAIT: begin
        if (mac_done) begin
          wb_nxt    = mac_status & STAT_HW_MASK;
          wb_nxt[ERR_ANY_BIT] = |(mac_status & STAT_ERR_MASK);
          state_nxt = S_WBACK;
        end
      end
      S_WBACK: begin
        if (mem_ack) begin
          ev[IRQ_DONE] = ctl_r[NOTIFY_BIT] && final_seg;
          ev[IRQ_ERR]  = wb_r[ERR_ANY_BIT];
          state_nxt    = S_NEXT;
        end
      end
      S_NEXT: begin
        if (ctl_r[WRAP_BIT]) begin
          cur_nxt = base_r;
        end else if (chain_eff) begin
          cur_nxt = ptr2_r & ALIGN_MASK;
        end else begin
          cur_nxt = cur_r + DESC_STRIDE;
        end
        idx_nxt   = 2'b00;
        state_nxt = en_r ? S_FETCH : S_IDLE;
      end
      default: state_nxt = S_IDLE;
    endcase
    if (tx_valid && tx_ready) begin
      first_nxt = 1'b0;
    end
    if (reg_wr && reg_addr == REG_BASE) begin
      cur_nxt = reg_wdata & ALIGN_MASK;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_r <= S_IDLE;
      idx_r   <= '0;
      stat_r  <= '0;
      ctl_r   <= '0;
      ptr1_r  <= '0;
      ptr2_r  <= '0;
      cur_r   <= '0;
      wb_r    <= '0;
      first_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      idx_r   <= idx_nxt;
      stat_r  <= stat_nxt;
      ctl_r   <= ctl_nxt;
      ptr1_r  <= ptr1_nxt;
      ptr2_r  <= ptr2_nxt;
      cur_r   <= cur_nxt;
      wb_r    <= wb_nxt;
      first_r <= first_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Buffer streaming
  txdh_byte_reader #(
    .LW(LEN_W)
  ) u_reader (
    .clk       (clk),
    .reset     (reset),
    .start     (rd_start),
    .start_addr(rd_addr),
    .start_len (rd_len),
    .mem_req   (rd_req),
    .mem_addr  (rd_maddr),
    .mem_ack   (mem_ack && in_buf),
    .mem_rdata (mem_rdata),
    .byte_data (tx_data),
    .byte_valid(rd_valid),
    .byte_ready(tx_ready),
    .byte_last (rd_last),
    .done      (rd_done)
  );

  assign tx_valid  = rd_valid && in_buf;
  assign tx_first  = first_r;
  assign tx_last   = rd_last && final_seg && ((state_r == S_BUF2) || !use_buf2);
  assign tx_no_fcs = ctl_r[NO_FCS_BIT];
  assign tx_no_pad = ctl_r[NO_PAD_BIT];

  // Memory port: descriptor words, buffer words, status write-back
  assign mem_req   = (state_r == S_FETCH) || (state_r == S_WBACK) || (in_buf && rd_req);
  assign mem_we    = (state_r == S_WBACK);
  assign mem_addr  = in_buf ? rd_maddr :
                     (state_r == S_WBACK) ? (cur_r + DESC_STATUS_OFS) :
                     (cur_r + {28'h000_0000, idx_r, 2'b00});
  assign mem_wdata = wb_r;

  ////////////////////////////////////////////////////////////////////////////
  // Register port and interrupt
  always_comb begin
    en_nxt    = en_r;
    poll_nxt  = poll_r && (state_r != S_IDLE);
    base_nxt  = base_r;
    imask_nxt = imask_r;
    ist_nxt   = ist_r;
    rdata_nxt = '0;
    if (reg_wr) begin
      case (reg_addr)
        REG_CTRL:     en_nxt    = reg_wdata[CTRL_EN_BIT];
        REG_POLL:     poll_nxt  = 1'b1;
        REG_BASE:     base_nxt  = reg_wdata & ALIGN_MASK;
        REG_IRQ_MASK: imask_nxt = reg_wdata[IRQ_W-1:0];
        default:      en_nxt    = en_r;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        REG_CTRL:     rdata_nxt = {31'h0000_0000, en_r};
        REG_BASE:     rdata_nxt = base_r;
        REG_CUR:      rdata_nxt = cur_r;
        REG_IRQ_STAT: rdata_nxt = {29'h0000_0000, ist_r};
        REG_IRQ_MASK: rdata_nxt = {29'h0000_0000, imask_r};
        REG_STATE:    rdata_nxt = {29'h0000_0000, state_r};
        default:      rdata_nxt = '0;
      endcase
      if (reg_addr == REG_IRQ_STAT) begin
        ist_nxt = '0;
      end
    end
    ist_nxt = ist_nxt | ev;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      en_r    <= 1'b0;
      poll_r  <= 1'b0;
      base_r  <= '0;
      imask_r <= '0;
      ist_r   <= '0;
      rdata_r <= '0;
    end else begin
      en_r    <= en_nxt;
      poll_r  <= poll_nxt;
      base_r  <= base_nxt;
      imask_r <= imask_nxt;
      ist_r   <= ist_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign irq       = |(ist_r & imask_r);

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  AST_DESC_ALIGN: assert property (@(posedge clk) disable iff (reset)
    (mem_req && !in_buf) |-> (mem_addr[1:0] == 2'b00))
    else $error("descriptor access not longword aligned");

  AST_FOUR_WORDS: assert property (@(posedge clk) disable iff (reset)
    (state_r == S_CHECK) |-> ($past(state_r) == S_FETCH && $past(idx_r) == 2'b11))
    else $error("descriptor checked before all four words were read");

  AST_NOT_OWNED: assert property (@(posedge clk) disable iff (reset)
    (state_r == S_CHECK && !stat_r[OWN_BIT]) |=> (state_r == S_IDLE && !tx_valid) ##1 !tx_valid)
    else $error("descriptor without hand-over flag was used");

  AST_WB_RELEASE: assert property (@(posedge clk) disable iff (reset)
    (mem_req && mem_we) |-> !mem_wdata[OWN_BIT])
    else $error("status write-back kept the hand-over flag");

  AST_ERR_ANY: assert property (@(posedge clk) disable iff (reset)
    (mem_req && mem_we) |-> (mem_wdata[ERR_ANY_BIT] == |(mem_wdata & STAT_ERR_MASK)))
    else $error("error_any does not match the error bits");

  AST_CHAIN: assert property (@(posedge clk) disable iff (reset)
    (state_r == S_NEXT && ctl_r[CHAIN_BIT] && !ctl_r[WRAP_BIT] && !reg_wr)
      |=> (cur_r == ($past(ptr2_r) & ALIGN_MASK)))
    else $error("chained descriptor not followed");

  AST_CHAIN_NO_DATA: assert property (@(posedge clk) disable iff (reset)
    (state_r == S_BUF1 && rd_done && chain_eff) |=> (state_r != S_BUF2))
    else $error("chain pointer sent as a data buffer");

  AST_NO_FCS: assert property (@(posedge clk) disable iff (reset)
    (state_r == S_FETCH && mem_ack && idx_r == 2'b01)
      |=> (tx_no_fcs == $past(mem_rdata[NO_FCS_BIT])))
    else $error("frame check suppression not presented with data");

  AST_RING_WINS: assert property (@(posedge clk) disable iff (reset)
    (state_r == S_NEXT && ctl_r[WRAP_BIT] && ctl_r[CHAIN_BIT] && !reg_wr)
      |=> (cur_r == $past(base_r)))
    else $error("chain taken over ring wrap");

  AST_WRAP: assert property (@(posedge clk) disable iff (reset)
    (state_r == S_NEXT && ctl_r[WRAP_BIT] && !reg_wr) |=> (cur_r == $past(base_r)))
    else $error("wrap did not return to list base");
endmodule
`default_nettype wire

// *** logic/txdh_pkg.sv ***
// Constants, field layout and state types of the transmit descriptor handler.
// Assumes a 32-bit little-endian host memory reached by longword accesses.
package txdh_pkg;
  // Register port map
  localparam int          REG_AW         = 8;
  localparam logic [7:0]  REG_CTRL       = 8'h00;
  localparam logic [7:0]  REG_POLL       = 8'h04;
  localparam logic [7:0]  REG_BASE       = 8'h08;
  localparam logic [7:0]  REG_CUR        = 8'h0C;
  localparam logic [7:0]  REG_IRQ_STAT   = 8'h10;
  localparam logic [7:0]  REG_IRQ_MASK   = 8'h14;
  localparam logic [7:0]  REG_STATE      = 8'h18;
  localparam int          CTRL_EN_BIT    = 0;
  // Descriptor word offsets and stride
  localparam logic [31:0] DESC_STATUS_OFS = 32'h0000_0000;
  localparam logic [31:0] DESC_CTRL_OFS   = 32'h0000_0004;
  localparam logic [31:0] DESC_PTR1_OFS   = 32'h0000_0008;
  localparam logic [31:0] DESC_PTR2_OFS   = 32'h0000_000C;
  localparam logic [31:0] DESC_STRIDE     = 32'h0000_0010;
  localparam logic [31:0] WORD_STEP       = 32'h0000_0004;
  localparam logic [31:0] ALIGN_MASK      = 32'hFFFF_FFFC;
  localparam int          DESC_WORDS      = 4;
  // Status word fields
  localparam int          OWN_BIT        = 31;
  localparam int          ERR_ANY_BIT    = 15;
  localparam logic [31:0] STAT_HW_MASK   = 32'h00C0_4FFB;
  localparam logic [31:0] STAT_ERR_MASK  = 32'h0000_4F02;
  // Control word fields
  localparam int          NOTIFY_BIT     = 31;
  localparam int          FINAL_BIT      = 30;
  localparam int          FIRST_BIT      = 29;
  localparam int          NO_FCS_BIT     = 26;
  localparam int          WRAP_BIT       = 25;
  localparam int          CHAIN_BIT      = 24;
  localparam int          NO_PAD_BIT     = 23;
  localparam int          LEN_W          = 11;
  localparam int          LEN2_LSB       = 11;
  localparam int          LEN1_LSB       = 0;
  // Interrupt status bits
  localparam int          IRQ_W          = 3;
  localparam int          IRQ_DONE       = 0;
  localparam int          IRQ_EMPTY      = 1;
  localparam int          IRQ_ERR        = 2;

  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_FETCH = 3'b001,
    S_CHECK = 3'b010,
    S_BUF1  = 3'b011,
    S_BUF2  = 3'b100,
    S_WAIT  = 3'b101,
    S_WBACK = 3'b110,
    S_NEXT  = 3'b111
  } txdh_state_t;

  typedef enum logic [1:0] {
    R_IDLE = 2'b00,
    R_REQ  = 2'b01,
    R_EMIT = 2'b10
  } txdh_rd_state_t;
endpackage

// *** logic/txdh_byte_reader.sv ***
// Byte reader: streams a buffer of any byte address and length from memory.
// Assumes memory answers a held request with a one-cycle ack and read word.
`timescale 1ns/1ps
`default_nettype none
module txdh_byte_reader import txdh_pkg::*; #(
  parameter int LW = LEN_W
) (
  input  wire logic          clk,
  input  wire logic          reset,
  input  wire logic          start,
  input  wire logic [31:0]   start_addr,
  input  wire logic [LW-1:0] start_len,
  output logic               mem_req,
  output logic [31:0]        mem_addr,
  input  wire logic          mem_ack,
  input  wire logic [31:0]   mem_rdata,
  output logic [7:0]         byte_data,
  output logic               byte_valid,
  input  wire logic          byte_ready,
  output logic               byte_last,
  output logic               done
);
  txdh_rd_state_t st_r, st_nxt;
  logic [31:0]   addr_r, addr_nxt, word_r, word_nxt;
  logic [LW-1:0] left_r, left_nxt;

  always_comb begin
    st_nxt   = st_r;
    addr_nxt = addr_r;
    word_nxt = word_r;
    left_nxt = left_r;
    done     = 1'b0;
    case (st_r)
      R_IDLE: begin
        if (start) begin
          addr_nxt = start_addr;
          left_nxt = start_len;
          if (start_len == '0) begin
            done = 1'b1;
          end else begin
            st_nxt = R_REQ;
          end
        end
      end
      R_REQ: begin
        if (mem_ack) begin
          word_nxt = mem_rdata;
          st_nxt   = R_EMIT;
        end
      end
      R_EMIT: begin
        if (byte_ready) begin
          addr_nxt = addr_r + 32'h0000_0001;
          left_nxt = left_r - LW'(1);
          if (left_r == LW'(1)) begin
            done   = 1'b1;
            st_nxt = R_IDLE;
            // Next buffer may be started in the finishing cycle
            if (start && start_len != '0) begin
              addr_nxt = start_addr;
              left_nxt = start_len;
              st_nxt   = R_REQ;
            end
          end else if (addr_r[1:0] == 2'b11) begin
            st_nxt = R_REQ;
          end
        end
      end
      default: st_nxt = R_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st_r   <= R_IDLE;
      addr_r <= '0;
      word_r <= '0;
      left_r <= '0;
    end else begin
      st_r   <= st_nxt;
      addr_r <= addr_nxt;
      word_r <= word_nxt;
      left_r <= left_nxt;
    end
  end

  // Word fetch is aligned; the lane picks the exact starting byte
  assign mem_req    = (st_r == R_REQ);
  assign mem_addr   = addr_r & ALIGN_MASK;
  assign byte_data  = word_r[{addr_r[1:0], 3'b000} +: 8];
  assign byte_valid = (st_r == R_EMIT);
  assign byte_last  = (st_r == R_EMIT) && (left_r == LW'(1));

  AST_START_BYTE: assert property (@(posedge clk) disable iff (reset)
    (st_r == R_IDLE && start && start_len != '0) |=> (addr_r == $past(start_addr)))
    else $error("reader did not latch the exact start byte");
endmodule
`default_nettype wire

// *** verification/txdh_mem_model.sv ***
// Host memory model: a sparse word store that serves the engine's requests.
// Assumes requests hold until ack; slow adds 0 to 3 wait cycles per request.
`timescale 1ns/1ps
`default_nettype none
module txdh_mem_model (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [31:0] mem_addr,
  input  wire logic [31:0] mem_wdata,
  input  wire logic [1:0]  slow,
  output logic             mem_ack,
  output logic      [31:0] mem_rdata
);
  logic [31:0] mem [logic [31:0]];
  logic [1:0]  wait_r;
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      mem_ack   <= 1'b0;
      mem_rdata <= 32'h0000_0000;
      wait_r    <= 2'h0;
    end else begin
      mem_ack   <= 1'b0;
      // Read data only holds meaning beside ack
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ack) begin
        if (wait_r >= slow) begin
          mem_ack <= 1'b1;
          wait_r  <= 2'h0;
          if (mem_we) mem[mem_addr] = mem_wdata;
          else mem_rdata <= mem.exists(mem_addr) ? mem[mem_addr] : 32'h0000_0000;
        end else begin
          wait_r <= wait_r + 2'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** verification/txdh_tb_top.sv ***
// Self-checking bench of the transmit descriptor handler.
// Assumes the package and the memory model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin error_cnt++; \
  $display("mismatch %s exp %h got %h", nm, ex, got); end end
module txdh_tb_top import txdh_pkg::*;;
  logic        clk, reset, reg_wr, reg_rd, irq, mem_req, mem_we, mem_ack;
  logic        tx_valid, tx_first, tx_last, tx_no_fcs, tx_no_pad;
  logic        tx_ready = 1'b0;
  logic        mac_done = 1'b0;
  logic        rd_d = 1'b0;
  logic [7:0]  reg_addr, tx_data;
  logic [31:0] reg_wdata, reg_rdata, mem_addr, mem_wdata, mem_rdata, re;
  logic [31:0] mac_status = 32'h0000_0000;
  logic [31:0] seed = 32'h52b4_5146;
  logic [31:0] dseed = 32'h52b4_5146;
  logic [1:0]  slow = 2'h0;
  logic [12:0] te;
  logic [63:0] we;
  logic [12:0] tx_q[$];
  logic [31:0] rd_q[$];
  logic [31:0] mac_q[$];
  logic [63:0] wb_q[$];
  int          error_cnt = 0;
  int          checked = 0;
  int          c10c = 0;
  int          mac_cnt = 0;

  txdh_top dut_u (.clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq,
    .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata, .tx_data, .tx_valid,
    .tx_ready, .tx_first, .tx_last, .tx_no_fcs, .tx_no_pad, .mac_done, .mac_status);
  txdh_mem_model mem_u (.clk, .reset, .mem_req, .mem_we, .mem_addr, .mem_wdata, .slow,
    .mem_ack, .mem_rdata);

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Status written back: kept fields, summary bit, hand-over bit clear
  function automatic logic [31:0] wbv(input logic [31:0] st);
    return (st & STAT_HW_MASK) | {16'h0000, |(st & STAT_ERR_MASK), 15'h0000};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Random stalls, memory latency and the MAC completion pulse
  always @(posedge clk) begin
    seed     <= lfsr(seed);
    tx_ready <= seed[0] | seed[1];
    slow     <= seed[3:2];
    mac_done <= 1'b0;
    if (mac_cnt == 1) begin
      mac_done   <= 1'b1;
      mac_status <= mac_q.pop_front();
    end
    if (mac_cnt > 0) mac_cnt <= mac_cnt - 1;
    if (tx_valid && tx_ready && tx_last) mac_cnt <= 4;
  end

  // Result watcher: every result takes the oldest note of its queue
  always @(posedge clk) begin
    rd_d <= reg_rd;
    if (rd_d) begin
      re = rd_q.pop_front();
      `CHK("reg_rdata", re, reg_rdata)
    end
    if (tx_valid && tx_ready) begin
      te = tx_q.size() ? tx_q.pop_front() : 13'h0000;
      `CHK("tx_byte", te, {1'b1, tx_first, tx_last, tx_no_fcs, tx_no_pad, tx_data})
    end
    if (mem_req && mem_ack && mem_we) begin
      we = wb_q.size() ? wb_q.pop_front() : 64'h0000_0000_0000_0000;
      `CHK("writeback", we, {mem_addr, mem_wdata})
    end
    if (mem_req && mem_ack && !mem_we && mem_addr == 32'h0000_010C) c10c++;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
  endtask
  // Fill a buffer with random bytes; fl = first, last, no_fcs, no_pad
  task automatic put(input logic [31:0] a, input int n, input logic [3:0] fl);
    for (int i = 0; i < n; i++) begin
      logic [31:0] ba;
      logic [31:0] wa;
      ba = a + 32'(i);
      wa = ba & ALIGN_MASK;
      dseed = lfsr(dseed);
      if (!mem_u.mem.exists(wa)) mem_u.mem[wa] = 32'h0000_0000;
      mem_u.mem[wa][8 * ba[1:0] +: 8] = dseed[7:0];
      tx_q.push_back({1'b1, fl[3] && i == 0, fl[2] && i == n - 1, fl[1:0], dseed[7:0]});
    end
  endtask
  task automatic desc(input logic [31:0] a, c, p1, p2);
    mem_u.mem[a] = 32'h8000_0000;
    mem_u.mem[a + DESC_CTRL_OFS] = c;
    mem_u.mem[a + DESC_PTR1_OFS] = p1;
    mem_u.mem[a + DESC_PTR2_OFS] = p2;
  endtask
  task automatic tally_and_finish;
    if (error_cnt == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic wait_fetch(input int n);
    int k;
    k = 0;
    while (c10c < n && k < 5000) begin
      @(posedge clk);
      k++;
    end
    if (c10c < n) begin
      error_cnt++;
      $display("mismatch fetch_count exp %0d got %0d", n, c10c);
      tally_and_finish;
    end
    repeat (4) @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    reset = 1'b1;
    {reg_wr, reg_rd} = '0;
    {reg_addr, reg_wdata} = '0;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    wr(REG_IRQ_MASK, 32'h0000_0007);
    wr(REG_BASE, 32'h0000_0102);
    rd(REG_CUR, 32'h0000_0100);
    rd(8'h40, 32'h0000_0000);
    wr(REG_CUR, 32'h0000_0500);
    rd(REG_CUR, 32'h0000_0100);
    wr(REG_CTRL, 32'h0000_0001);
    wr(REG_POLL, 32'h0000_0000);
    wait_fetch(1);
    @(negedge clk);
    `CHK("irq", 1'b1, irq)
    rd(REG_IRQ_STAT, 32'h0000_0002);
    rd(REG_IRQ_STAT, 32'h0000_0000);
    // Descriptors at longword addresses; buffers at unaligned byte addresses
    desc(32'h0000_0100, 32'hE400_1003, 32'h0000_1001, 32'h0000_2003);
    put(32'h0000_1001, 3, 4'b1010);
    put(32'h0000_2003, 2, 4'b0110);
    desc(32'h0000_0110, 32'h2100_2802, 32'h0000_4002, 32'h0000_0300);
    put(32'h0000_4002, 2, 4'b1000);
    desc(32'h0000_0300, 32'h4380_0001, 32'h0000_3003, 32'h0000_0700);
    put(32'h0000_3003, 1, 4'b0101);
    mac_q.push_back(32'h8001_0218);
    mac_q.push_back(32'h0040_0001);
    wb_q.push_back({32'h0000_0100, wbv(32'h8001_0218)});
    wb_q.push_back({32'h0000_0110, 32'h0000_0000});
    wb_q.push_back({32'h0000_0300, wbv(32'h0040_0001)});
    wr(REG_POLL, 32'h0000_0000);
    wait_fetch(3);
    @(negedge clk);
    `CHK("irq", 1'b1, irq)
    rd(REG_IRQ_STAT, 32'h0000_0007);
    rd(REG_CUR, 32'h0000_0100);
    rd(REG_BASE, 32'h0000_0100);
    rd(REG_IRQ_MASK, 32'h0000_0007);
    rd(REG_CTRL, 32'h0000_0001);
    rd(REG_STATE, {29'h0000_0000, S_IDLE});
    @(negedge clk);
    `CHK("irq", 1'b0, irq)
    `CHK("bytes_left", 0, tx_q.size())
    `CHK("writebacks_left", 0, wb_q.size())
    tally_and_finish;
  end
endmodule
`default_nettype wire
